// ===== design/ssge_top.sv
// module: serial shift gpio expander with wishbone registers and detect override
`timescale 1ns/1ps

// How it works
// - up to 128 serial bits, as 32 ports of four bits each
// - shift output bits out on data pin, then assert load strobe
// - sample data input while shifting; software reads the sampled bits
// - only enabled ports are shifted; disabled ports are skipped entirely
// - bits per enabled port selectable 1 to 4, same for all ports
// - enables and width govern input and output streams alike
// - bursts each end with load strobe; at most 32 by 4 bit cycles
// - repeat gap programmable in 1 ms steps, 0 to 33 ms, disable bit
// - one-shot launches exactly one burst; hardware clears it after that burst
// - repeat keeps issuing bursts separated by gap until software clears it
// - load strobe pulses once per burst for LD_CYC clocks, the fewest that cover LD_MIN_NS
// - load strobe active level selected by a control bit
// - shift clock frequency set by a clock-rate field
// - input and output port order reversible independently
// - output bits from per-bit source register; inputs in input register
// - sixteen detect inputs, when enabled replace mapped port's loss-of-signal
// - bit 0 of each port forwarded as that port's loss-of-signal
module ssge_top
	import ssge_pkg::*;
#(
	parameter int GAP_STEP_CYCLES = GAP_STEP_CYC
) (
	input  wire logic                  clk_i,              // system clock, 10 MHz
	input  wire logic                  rst_i,              // sync reset, active high
	input  wire logic                  ce_i,               // clock enable, freezes all
	input  wire logic                  wb_cyc_i,           // wishbone cycle
	input  wire logic                  wb_stb_i,           // wishbone strobe
	input  wire logic                  wb_we_i,            // wishbone write
	input  wire logic [7:0]            wb_adr_i,           // wishbone byte address
	input  wire logic [3:0]            wb_sel_i,           // wishbone byte enables
	input  wire logic [31:0]           wb_dat_i,           // wishbone write data
	output logic      [31:0]           wb_dat_o,           // wishbone read data
	output logic                       wb_ack_o,           // wishbone ack
	output logic                       shift_clock_out_o,  // serial shift clock
	output logic                       shift_data_out_o,   // serial data to chain
	input  wire logic                  shift_data_in_i,    // serial data from chain
	output logic                       load_strobe_o,      // load strobe pin
	input  wire logic [NUM_DETECT-1:0] parallel_detect_input_i, // detect pins
	output logic      [NUM_PORTS-1:0]  los_o               // loss-of-signal per port
);

	////////////////////////////////////////////////////////////////////////////
	// helpers

	// write byte lanes selected by sel
	function automatic logic [31:0] merge_sel(input logic [31:0] old,
		input logic [31:0] nw, input logic [3:0] sel);
		logic [31:0] r;
		r = old;
		for (int i = 0; i < 4; i++)
			if (sel[i])
				r[i*8 +: 8] = nw[i*8 +: 8];
		return r;
	endfunction : merge_sel

	// port mask in stream order
	function automatic logic [31:0] order_mask(input logic [31:0] m, input logic rev);
		logic [31:0] r;
		r = m;
		if (rev)
			for (int i = 0; i < NUM_PORTS; i++)
				r[i] = m[NUM_PORTS-1-i];
		return r;
	endfunction : order_mask

	// first enabled stream slot at or after from; 32 when none
	function automatic logic [5:0] next_port(input logic [31:0] m, input logic [5:0] from);
		logic [5:0] r;
		r = 6'h20;
		for (int i = NUM_PORTS-1; i >= 0; i--)
			if (m[i] && (6'(i) >= from))
				r = 6'(i);
		return r;
	endfunction : next_port

	// stream slot to physical bit index
	function automatic logic [6:0] bit_index(input logic [4:0] slot, input logic rev,
		input logic [1:0] b);
		logic [4:0] p;
		p = rev ? ~slot : slot;
		return {p, b};
	endfunction : bit_index

	////////////////////////////////////////////////////////////////////////////
	// registers

	logic                 one_shot_trigger_ff;
	logic                 repeat_bursts_ff;
	logic [1:0]           bits_per_port_ff;      // width minus one
	logic                 load_strobe_polarity_ff;
	logic                 input_order_reverse_ff;
	logic                 output_order_reverse_ff;
	logic                 burst_gap_disable_ff;
	logic [5:0]           burst_gap_length_ff;
	logic [7:0]           shift_clock_rate_ff;
	logic [31:0]          port_enable_mask_ff;
	logic [NUM_BITS-1:0]  out_src_ff;
	logic [NUM_BITS-1:0]  sampled_inputs_ff;
	logic [4:0]           detect_port_map_ff [NUM_DETECT];
	logic [NUM_DETECT-1:0] detect_ena_ff;
	logic                 ack_ff;
	logic [31:0]          rdata_ff;

	ssge_state_e          state_ff;
	ssge_state_e          nxt_state;
	logic [4:0]           out_slot_ff, nxt_out_slot;
	logic [4:0]           in_slot_ff, nxt_in_slot;
	logic [1:0]           bit_ff, nxt_bit;
	logic                 shot_taken_ff;
	logic                 burst_done;
	logic [5:0]           gap_ms_ff;
	logic [31:0]          gap_step_ff;
	logic [31:0]          ld_cnt_ff;
	logic                 sck_ff;
	logic                 sdo_ff;
	logic                 ld_ff;
	logic [NUM_PORTS-1:0] los_ff;

	logic                  sdi_s;
	logic [NUM_DETECT-1:0] det_s;
	logic                  wr_en;
	logic [31:0]           cfg_wr;
	logic [31:0]           m_out, m_in;
	logic [5:0]            first_out, first_in, adv_out, adv_in;
	logic [5:0]            gap_eff;

	ssge_tick_if tk ();

	////////////////////////////////////////////////////////////////////////////
	// pin synchronisers and shift clock divider

	ssge_sync #(.W(1)) u_sync_sdi (
		.clk_i (clk_i),
		.rst_i (rst_i),
		.ce_i  (ce_i),
		.d_i   (shift_data_in_i),
		.q_o   (sdi_s)
	);

	ssge_sync #(.W(NUM_DETECT)) u_sync_det (
		.clk_i (clk_i),
		.rst_i (rst_i),
		.ce_i  (ce_i),
		.d_i   (parallel_detect_input_i),
		.q_o   (det_s)
	);

	ssge_clk_div u_div (
		.clk_i (clk_i),
		.rst_i (rst_i),
		.ce_i  (ce_i),
		.tk    (tk.div)
	);

	assign tk.run  = (state_ff == ST_LOW) || (state_ff == ST_HIGH);
	assign tk.rate = shift_clock_rate_ff;

	////////////////////////////////////////////////////////////////////////////
	// wishbone slave: answer one cycle after request, write at the ack edge

	assign wr_en  = wb_cyc_i && wb_stb_i && wb_we_i && ack_ff;
	assign cfg_wr = merge_sel(32'h0, wb_dat_i, wb_sel_i);

	// ack and registered read data
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			ack_ff   <= 1'b0;
			rdata_ff <= 32'h0;
		end
		else if (ce_i)
		begin
			ack_ff   <= wb_cyc_i && wb_stb_i && !ack_ff;
			rdata_ff <= 32'h0;  // zero outside the answer cycle
			if (!wb_cyc_i || !wb_stb_i || ack_ff)
				rdata_ff <= 32'h0;
			else if (wb_adr_i == OFS_CFG)
				rdata_ff <= {!(state_ff == ST_IDLE), 16'h0, 1'b0, burst_gap_length_ff,
					burst_gap_disable_ff, output_order_reverse_ff, input_order_reverse_ff,
					load_strobe_polarity_ff, bits_per_port_ff, repeat_bursts_ff,
					one_shot_trigger_ff};
			else if (wb_adr_i == OFS_CLOCK)
				rdata_ff <= {24'h0, shift_clock_rate_ff};
			else if (wb_adr_i == OFS_PORT_ENA)
				rdata_ff <= port_enable_mask_ff;
			else if (wb_adr_i[7:4] == OFS_OUT_BASE[7:4] && wb_adr_i[1:0] == 2'h0)
				rdata_ff <= out_src_ff[wb_adr_i[3:2]*32 +: 32];
			else if (wb_adr_i[7:4] == OFS_IN_BASE[7:4] && wb_adr_i[1:0] == 2'h0)
				rdata_ff <= sampled_inputs_ff[wb_adr_i[3:2]*32 +: 32];
			else if (wb_adr_i == OFS_LOS)
				rdata_ff <= los_ff;
			else if (wb_adr_i[7:6] == OFS_MAP_BASE[7:6] && wb_adr_i[1:0] == 2'h0)
				rdata_ff <= {23'h0, detect_ena_ff[wb_adr_i[5:2]], 3'h0,
					detect_port_map_ff[wb_adr_i[5:2]]};
		end
	end

	assign wb_ack_o = ack_ff;
	assign wb_dat_o = rdata_ff;

	// control word; software set of one-shot beats the hardware clear
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			one_shot_trigger_ff     <= 1'b0;
			repeat_bursts_ff        <= 1'b0;
			bits_per_port_ff        <= RST_WIDTH;
			load_strobe_polarity_ff <= RST_LD_POL;
			input_order_reverse_ff  <= 1'b0;
			output_order_reverse_ff <= 1'b0;
			burst_gap_disable_ff    <= 1'b0;
			burst_gap_length_ff     <= RST_GAP;
		end
		else if (ce_i)
		begin
			if (wr_en && wb_adr_i == OFS_CFG && wb_sel_i[0])
			begin
				one_shot_trigger_ff     <= cfg_wr[CFG_ONE_SHOT];
				repeat_bursts_ff        <= cfg_wr[CFG_REPEAT];
				bits_per_port_ff        <= cfg_wr[CFG_WIDTH_LO +: 2];
				load_strobe_polarity_ff <= cfg_wr[CFG_LD_POL];
				input_order_reverse_ff  <= cfg_wr[CFG_REV_IN];
				output_order_reverse_ff <= cfg_wr[CFG_REV_OUT];
				burst_gap_disable_ff    <= cfg_wr[CFG_GAP_DIS];
			end
			else if (burst_done && shot_taken_ff)
			begin
				one_shot_trigger_ff <= 1'b0;
			end
			if (wr_en && wb_adr_i == OFS_CFG && wb_sel_i[1])
				burst_gap_length_ff <= cfg_wr[CFG_GAP_LO +: 6];
		end
	end

	// clock rate, enables, output sources, detect map
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			shift_clock_rate_ff <= RST_CLK_RATE;
			port_enable_mask_ff <= RST_PORT_ENA;
			out_src_ff          <= '0;
			detect_ena_ff       <= '0;
			for (int n = 0; n < NUM_DETECT; n++)
				detect_port_map_ff[n] <= 5'h00;
		end
		else if (ce_i && wr_en)
		begin
			if (wb_adr_i == OFS_CLOCK && wb_sel_i[0])
				shift_clock_rate_ff <= wb_dat_i[7:0];
			if (wb_adr_i == OFS_PORT_ENA)
				port_enable_mask_ff <= merge_sel(port_enable_mask_ff, wb_dat_i, wb_sel_i);
			if (wb_adr_i[7:4] == OFS_OUT_BASE[7:4] && wb_adr_i[1:0] == 2'h0)
				out_src_ff[wb_adr_i[3:2]*32 +: 32] <=
					merge_sel(out_src_ff[wb_adr_i[3:2]*32 +: 32], wb_dat_i, wb_sel_i);
			if (wb_adr_i[7:6] == OFS_MAP_BASE[7:6] && wb_adr_i[1:0] == 2'h0)
			begin
				if (wb_sel_i[0])
					detect_port_map_ff[wb_adr_i[5:2]] <= wb_dat_i[4:0];
				if (wb_sel_i[1])
					detect_ena_ff[wb_adr_i[5:2]] <= wb_dat_i[MAP_ENA];
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// burst sequencer

	// both streams walk the same enabled set, each in its own order
	assign m_out     = order_mask(port_enable_mask_ff, output_order_reverse_ff);
	assign m_in      = order_mask(port_enable_mask_ff, input_order_reverse_ff);
	assign first_out = next_port(m_out, 6'h00);
	assign first_in  = next_port(m_in, 6'h00);
	assign adv_out   = next_port(m_out, {1'b0, out_slot_ff} + 6'h01);
	assign adv_in    = next_port(m_in, {1'b0, in_slot_ff} + 6'h01);
	assign gap_eff   = (burst_gap_length_ff > GAP_MAX_MS) ? GAP_MAX_MS : burst_gap_length_ff;
	assign burst_done = (state_ff == ST_LOAD) && (ld_cnt_ff == 32'(LD_CYC - 1));

	// next state and stream position
	always_comb
	begin
		nxt_state    = state_ff;
		nxt_out_slot = out_slot_ff;
		nxt_in_slot  = in_slot_ff;
		nxt_bit      = bit_ff;
		unique case (state_ff)
			ST_IDLE:
			begin
				if (one_shot_trigger_ff || repeat_bursts_ff)
				begin
					nxt_out_slot = first_out[4:0];
					nxt_in_slot  = first_in[4:0];
					nxt_bit      = 2'h0;
					nxt_state    = first_out[5] ? ST_LOAD : ST_LOW;
				end
			end
			ST_LOW:
			begin
				if (tk.tick)
					nxt_state = ST_HIGH;
			end
			ST_HIGH:
			begin
				if (tk.tick)
				begin
					if (bit_ff != bits_per_port_ff)
					begin
						nxt_bit   = bit_ff + 2'h1;
						nxt_state = ST_LOW;
					end
					else
					begin
						nxt_bit      = 2'h0;
						nxt_out_slot = adv_out[4:0];
						nxt_in_slot  = adv_in[4:0];
						nxt_state    = adv_out[5] ? ST_LOAD : ST_LOW;
					end
				end
			end
			ST_LOAD:
			begin
				if (burst_done)
				begin
					if (repeat_bursts_ff && !burst_gap_disable_ff && gap_eff != 6'h00)
						nxt_state = ST_GAP;
					else
						nxt_state = ST_IDLE;
				end
			end
			ST_GAP:
			begin
				if (!repeat_bursts_ff ||
					(gap_ms_ff == 6'h01 && gap_step_ff == 32'(GAP_STEP_CYCLES - 1)))
					nxt_state = ST_IDLE;
			end
		endcase
	end

	// state, position and burst ownership of the one-shot
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			state_ff      <= ST_IDLE;
			out_slot_ff   <= 5'h00;
			in_slot_ff    <= 5'h00;
			bit_ff        <= 2'h0;
			shot_taken_ff <= 1'b0;
		end
		else if (ce_i)
		begin
			state_ff    <= nxt_state;
			out_slot_ff <= nxt_out_slot;
			in_slot_ff  <= nxt_in_slot;
			bit_ff      <= nxt_bit;
			if (state_ff == ST_IDLE && nxt_state != ST_IDLE)
				shot_taken_ff <= one_shot_trigger_ff;
		end
	end

	// gap timer in millisecond steps
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			gap_ms_ff   <= 6'h00;
			gap_step_ff <= 32'h0;
		end
		else if (ce_i)
		begin
			if (state_ff != ST_GAP)
			begin
				gap_ms_ff   <= gap_eff;
				gap_step_ff <= 32'h0;
			end
			else if (gap_step_ff == 32'(GAP_STEP_CYCLES - 1))
			begin
				gap_ms_ff   <= gap_ms_ff - 6'h01;
				gap_step_ff <= 32'h0;
			end
			else
			begin
				gap_step_ff <= gap_step_ff + 32'h1;
			end
		end
	end

	// load strobe length counter
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
			ld_cnt_ff <= 32'h0;
		else if (ce_i)
			ld_cnt_ff <= (state_ff == ST_LOAD && !burst_done) ? ld_cnt_ff + 32'h1 : 32'h0;
	end

	////////////////////////////////////////////////////////////////////////////
	// serial pins and sampling

	// clock high in second half, data set as the clock falls, strobe per burst
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			sck_ff <= 1'b0;
			sdo_ff <= 1'b0;
			ld_ff  <= !RST_LD_POL;
		end
		else if (ce_i)
		begin
			sck_ff <= (nxt_state == ST_HIGH);
			if (nxt_state == ST_LOW)
				sdo_ff <= out_src_ff[bit_index(nxt_out_slot,
					output_order_reverse_ff, nxt_bit)];
			ld_ff <= (nxt_state == ST_LOAD) ? load_strobe_polarity_ff
				: !load_strobe_polarity_ff;
		end
	end

	assign shift_clock_out_o = sck_ff;
	assign shift_data_out_o  = sdo_ff;
	assign load_strobe_o     = ld_ff;

	// capture the returning bit as the shift clock rises
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
			sampled_inputs_ff <= '0;
		else if (ce_i && state_ff == ST_LOW && tk.tick)
			sampled_inputs_ff[bit_index(in_slot_ff, input_order_reverse_ff, bit_ff)]
				<= sdi_s;
	end

	// loss-of-signal per port, lowest enabled detect input wins
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
			los_ff <= '0;
		else if (ce_i)
			for (int p = 0; p < NUM_PORTS; p++)
			begin
				los_ff[p] <= sampled_inputs_ff[p*BITS_PER_PORT];
				for (int n = NUM_DETECT-1; n >= 0; n--)
					if (detect_ena_ff[n] && detect_port_map_ff[n] == 5'(p))
						los_ff[p] <= det_s[n];
			end
	end

	assign los_o = los_ff;

endmodule : ssge_top

// ===== design/ssge_pkg.sv
// package: register map, field layout, reset values and timing of the serial expander
package ssge_pkg;

	////////////////////////////////////////////////////////////////////////////
	// sizes
	localparam int NUM_PORTS     = 32;
	localparam int BITS_PER_PORT = 4;
	localparam int NUM_BITS      = NUM_PORTS * BITS_PER_PORT;
	localparam int NUM_DETECT    = 16;

	////////////////////////////////////////////////////////////////////////////
	// register byte offsets
	localparam logic [7:0] OFS_CFG      = 8'h00;
	localparam logic [7:0] OFS_CLOCK    = 8'h04;
	localparam logic [7:0] OFS_PORT_ENA = 8'h08;
	localparam logic [7:0] OFS_OUT_BASE = 8'h10;
	localparam logic [7:0] OFS_IN_BASE  = 8'h20;
	localparam logic [7:0] OFS_LOS      = 8'h30;
	localparam logic [7:0] OFS_MAP_BASE = 8'h40;

	////////////////////////////////////////////////////////////////////////////
	// control word field positions
	localparam int CFG_ONE_SHOT  = 0;
	localparam int CFG_REPEAT    = 1;
	localparam int CFG_WIDTH_LO  = 2;
	localparam int CFG_LD_POL    = 4;
	localparam int CFG_REV_IN    = 5;
	localparam int CFG_REV_OUT   = 6;
	localparam int CFG_GAP_DIS   = 7;
	localparam int CFG_GAP_LO    = 8;
	localparam int CFG_BUSY      = 31;
	localparam int MAP_ENA       = 8;

	////////////////////////////////////////////////////////////////////////////
	// reset values
	localparam logic [1:0]  RST_WIDTH    = 2'h3;
	localparam logic        RST_LD_POL   = 1'b1;
	localparam logic [5:0]  RST_GAP      = 6'h00;
	localparam logic [7:0]  RST_CLK_RATE = 8'h04;
	localparam logic [31:0] RST_PORT_ENA = 32'hffffffff;

	////////////////////////////////////////////////////////////////////////////
	// timing
	localparam int CLK_PERIOD_NS = 100;
	localparam int LD_MIN_NS     = 25;
	localparam int LD_MAX_NS     = 30;
	localparam int LD_CYC_RAW    = (LD_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int LD_CYC        = (LD_CYC_RAW < 1) ? 1 : LD_CYC_RAW;
	localparam int GAP_STEP_US   = 1000;
	localparam int GAP_STEP_CYC  = GAP_STEP_US * 1000 / CLK_PERIOD_NS;
	localparam logic [5:0] GAP_MAX_MS = 6'h21;

	////////////////////////////////////////////////////////////////////////////
	// burst sequencer states
	typedef enum logic [4:0] {
		ST_IDLE = 5'b00001,
		ST_LOW  = 5'b00010,
		ST_HIGH = 5'b00100,
		ST_LOAD = 5'b01000,
		ST_GAP  = 5'b10000
	} ssge_state_e;

endpackage : ssge_pkg

// ===== design/ssge_tick_if.sv
// interface: shift clock divider request and half-period tick
`timescale 1ns/1ps
interface ssge_tick_if;
	logic       run;   // divider counting
	logic [7:0] rate;  // half period minus two, in clk cycles
	logic       tick;  // end of a half period

	modport ctrl (output run, output rate, input tick);
	modport div  (input run, input rate, output tick);
endinterface : ssge_tick_if

// ===== design/ssge_sync.sv
// module: two-flop synchroniser for pins from outside the clock domain
`timescale 1ns/1ps
module ssge_sync #(
	parameter int W = 1
) (
	input  wire logic         clk_i,  // system clock
	input  wire logic         rst_i,  // sync reset, active high
	input  wire logic         ce_i,   // clock enable
	input  wire logic [W-1:0] d_i,    // asynchronous inputs
	output logic      [W-1:0] q_o     // synchronised outputs
);

	logic [W-1:0] meta_ff;

	// two stages, first read only by the second
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			meta_ff <= '0;
			q_o     <= '0;
		end
		else if (ce_i)
		begin
			meta_ff <= d_i;
			q_o     <= meta_ff;
		end
	end

endmodule : ssge_sync

// ===== design/ssge_clk_div.sv
// module: programmable divider giving the shift clock half-period tick
`timescale 1ns/1ps
module ssge_clk_div (
	input  wire logic clk_i,  // system clock
	input  wire logic rst_i,  // sync reset, active high
	input  wire logic ce_i,   // clock enable
	ssge_tick_if.div  tk      // run/rate in, tick out
);

	logic [7:0] cnt_ff;
	logic       tick_ff;

	// count rate+1 cycles then a tick cycle, rate+2 per half period, restart when idle
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			cnt_ff  <= 8'h00;
			tick_ff <= 1'b0;
		end
		else if (ce_i)
		begin
			if (!tk.run || tick_ff)
			begin
				cnt_ff  <= 8'h00;
				tick_ff <= 1'b0;
			end
			else if (cnt_ff == tk.rate)
			begin
				cnt_ff  <= 8'h00;
				tick_ff <= 1'b1;
			end
			else
			begin
				cnt_ff <= cnt_ff + 8'h01;
			end
		end
	end

	assign tk.tick = tick_ff & tk.run;

endmodule : ssge_clk_div

// ===== verif/ssge_chk_sva.sv
// checker: bus and serial pin assertions for the expander top
`timescale 1ns/1ps
module ssge_chk
	import ssge_pkg::*;
#(
	parameter int GAP_STEP_CYCLES = GAP_STEP_CYC
) (
	input wire logic                 clk_i,             // clock
	input wire logic                 rst_i,             // reset
	input wire logic                 wb_cyc_i,          // bus cycle
	input wire logic                 wb_stb_i,          // bus strobe
	input wire logic                 wb_we_i,           // bus write
	input wire logic [31:0]          wb_dat_o,          // read data
	input wire logic                 wb_ack_o,          // bus ack
	input wire logic                 shift_clock_out_o, // shift clock
	input wire logic                 shift_data_out_o,  // serial out
	input wire logic                 load_strobe_o,     // load strobe
	input wire logic [NUM_PORTS-1:0] los_o              // loss of signal
);
	default clocking @(posedge clk_i); endclocking
	default disable iff (rst_i);

	////////////////////////////////////////////////////////////////////////
	// request taken, strobe raised other than by a polarity write
	sequence s_req;
		wb_cyc_i && wb_stb_i && !wb_ack_o;
	endsequence
	sequence s_ld_rise;
		$rose(load_strobe_o) && !($past(wb_ack_o, 2) && $past(wb_we_i, 2));
	endsequence

	a_ack_answer: assert property (s_req |=> wb_ack_o)
		else $error("no ack after request");
	a_ack_single: assert property (wb_ack_o |=> !wb_ack_o)
		else $error("ack longer than one cycle");
	a_ack_cause: assert property (wb_ack_o |-> $past(wb_cyc_i) && $past(wb_stb_i))
		else $error("ack without request");
	a_dat_quiet: assert property (!wb_ack_o |-> wb_dat_o == 32'h0)
		else $error("read data outside ack");
	a_data_hold_high: assert property (shift_clock_out_o |-> $stable(shift_data_out_o))
		else $error("data moved while shift clock high");
	a_load_clk_low: assert property ($changed(load_strobe_o) |-> !shift_clock_out_o)
		else $error("strobe moved while shift clock high");
	a_load_width: assert property (s_ld_rise |=> $fell(load_strobe_o))
		else $error("strobe not one cycle");
	a_reset_quiet: assert property ($fell(rst_i) |-> !shift_clock_out_o && los_o == '0)
		else $error("outputs not idle after reset");
endmodule : ssge_chk

bind ssge_top ssge_chk #(
	.GAP_STEP_CYCLES(GAP_STEP_CYCLES)
) u_chk (
	.clk_i(clk_i),
	.rst_i(rst_i),
	.wb_cyc_i(wb_cyc_i),
	.wb_stb_i(wb_stb_i),
	.wb_we_i(wb_we_i),
	.wb_dat_o(wb_dat_o),
	.wb_ack_o(wb_ack_o),
	.shift_clock_out_o(shift_clock_out_o),
	.shift_data_out_o(shift_data_out_o),
	.load_strobe_o(load_strobe_o),
	.los_o(los_o)
);

// ===== verif/ssge_chain_model.sv
// model: board chain of load-capable shift registers
`timescale 1ns/1ps
module ssge_chain_model #(
	parameter int N = 4
) (
	input  wire logic         sclk_i, // shift clock
	input  wire logic         sdo_i,  // serial data from block
	input  wire logic         ld_i,   // load strobe, active high
	input  wire logic [N-1:0] pin_i,  // parallel inputs
	output logic              sdi_o,  // serial data to block
	output logic      [N-1:0] pout_o  // parallel outputs
);
	logic [N-1:0] out_sr = '0;
	logic [N-1:0] in_sr  = '0;

	// shift both chains on the rising clock; refill with toggling bits
	always @(posedge sclk_i)
	begin
		out_sr <= {out_sr[N-2:0], sdo_i};
		in_sr  <= {in_sr[N-2:0], ~in_sr[0]};
	end

	// strobe applies outputs and captures inputs
	always @(posedge ld_i)
	begin
		pout_o <= out_sr;
		in_sr  <= pin_i;
	end

	assign sdi_o = in_sr[N-1];
endmodule : ssge_chain_model

// ===== verif/tb.sv
// testbench: register, burst, input, detect and polarity checks
`timescale 1ns/1ps
module tb;
	import ssge_pkg::*;
	logic        clk_i = 1'b0;
	logic        rst_i = 1'b1;
	logic        cyc   = 1'b0;
	logic        stb   = 1'b0;
	logic        we    = 1'b0;
	logic [7:0]  adr   = 8'h00;
	logic [31:0] wdat  = 32'h0;
	logic [15:0] det   = 16'h0;
	logic [3:0]  pin   = 4'hb;
	logic [31:0] rdat;
	logic [31:0] los;
	logic [31:0] q;
	logic [3:0]  pout;
	logic        ack;
	logic        sclk;
	logic        sdo;
	logic        sdi;
	logic        ld;
	int          bad_count = 0;
	int          compares  = 0;
	int          n0;
	int          n1;

	ssge_top #(.GAP_STEP_CYCLES(10)) dut (
		.clk_i(clk_i), .rst_i(rst_i), .ce_i(1'b1),
		.wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr),
		.wb_sel_i(4'hf), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack),
		.shift_clock_out_o(sclk), .shift_data_out_o(sdo),
		.shift_data_in_i(sdi), .load_strobe_o(ld),
		.parallel_detect_input_i(det), .los_o(los)
	);
	ssge_chain_model #(.N(4)) chain (
		.sclk_i(sclk), .sdo_i(sdo), .ld_i(ld), .pin_i(pin),
		.sdi_o(sdi), .pout_o(pout)
	);

	////////////////////////////////////////////////////////////////////////
	// clock and watchdog
	initial
	begin
		forever #50 clk_i = ~clk_i;
	end
	initial
	begin
		repeat (20000) @(posedge clk_i);
		bad_count++;
		end_sim();
	end

	////////////////////////////////////////////////////////////////////////
	// helpers
	task automatic end_sim();
		$display("mismatches %0d compares %0d", bad_count, compares);
		if (bad_count == 0 && compares > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask : end_sim
	task automatic chk(input logic [31:0] g, input logic [31:0] e);
		compares++;
		if (g !== e)
		begin
			bad_count++;
			$display("[FAIL] %0t got %h exp %h", $time, g, e);
		end
	endtask : chk
	task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge clk_i);
		cyc  <= 1'b1;
		stb  <= 1'b1;
		we   <= w;
		adr  <= a;
		wdat <= d;
		do @(posedge clk_i); while (ack !== 1'b1);
		q = rdat;
		cyc <= 1'b0;
		stb <= 1'b0;
	endtask : wb
	task automatic burst(input logic [31:0] cfg);
		wb(1'b1, OFS_CFG, cfg);
		do wb(1'b0, OFS_CFG, 32'h0); while (q[CFG_ONE_SHOT] !== 1'b0);
		chk({31'h0, q[CFG_BUSY]}, 32'h0);
	endtask : burst

	////////////////////////////////////////////////////////////////////////
	// scenarios
	task automatic t_reset();
		wb(1'b0, OFS_CFG, 32'h0);
		chk(q, 32'h0000001c);
		wb(1'b0, OFS_CLOCK, 32'h0);
		chk(q, 32'h00000004);
		wb(1'b0, OFS_PORT_ENA, 32'h0);
		chk(q, 32'hffffffff);
		wb(1'b1, OFS_IN_BASE, 32'hffffffff);
		wb(1'b0, OFS_IN_BASE, 32'h0);
		chk(q, 32'h0);
		wb(1'b0, 8'hfc, 32'h0);
		chk(q, 32'h0);
	endtask : t_reset
	task automatic t_out(input logic [31:0] cfg, input logic [3:0] e);
		wb(1'b1, OFS_OUT_BASE, 32'h00000215);
		burst(cfg);
		chk({28'h0, pout}, {28'h0, e});
	endtask : t_out
	task automatic t_in(input logic [31:0] cfg, input logic [31:0] e);
		burst(cfg);
		burst(cfg);
		wb(1'b0, OFS_IN_BASE, 32'h0);
		chk(q, e);
	endtask : t_in
	task automatic t_detect();
		chk({30'h0, los[2], los[0]}, 32'h3);
		wb(1'b1, OFS_MAP_BASE, 32'h00000000);
		wb(1'b1, OFS_MAP_BASE, 32'h00000100);
		det[0] <= 1'b0;
		repeat (5) @(posedge clk_i);
		chk({31'h0, los[0]}, 32'h0);
		det[0] <= 1'b1;
		repeat (5) @(posedge clk_i);
		chk({31'h0, los[0]}, 32'h1);
	endtask : t_detect
	task automatic t_rep(input logic [31:0] cfg, output int n);
		time t0;
		wb(1'b1, OFS_CFG, cfg);
		@(posedge ld);
		t0 = $time;
		@(posedge ld);
		n = int'(($time - t0) / CLK_PERIOD_NS);
		wb(1'b1, OFS_CFG, cfg & 32'hfffffffd);
		do wb(1'b0, OFS_CFG, 32'h0); while (q[CFG_BUSY] !== 1'b0);
		chk({31'h0, q[CFG_REPEAT]}, 32'h0);
	endtask : t_rep
	task automatic t_pol();
		wb(1'b1, OFS_CFG, 32'h0000000c);
		repeat (2) @(posedge clk_i);
		chk({31'h0, ld}, 32'h1);
	endtask : t_pol

	////////////////////////////////////////////////////////////////////////
	// main sequence
	initial
	begin
		repeat (12) @(posedge clk_i);
		rst_i <= 1'b0;
		t_reset();
		wb(1'b1, OFS_CLOCK, 32'h00000003);
		wb(1'b1, OFS_PORT_ENA, 32'h00000005);
		t_out(32'h00000015, 4'h9);
		t_out(32'h00000055, 4'h6);
		t_in(32'h00000015, 32'h00000301);
		t_detect();
		t_in(32'h00000035, 32'h00000103);
		t_rep(32'h00000296, n0);
		t_rep(32'h00000216, n1);
		chk(32'(n1 - n0), 32'h00000014);
		t_pol();
		end_sim();
	end
endmodule : tb
